// >>> logic/bus_node.sv
// Bus node of a synchronous backplane: host-side control and error/halt
// status with masks, a local processor decode, one data memory page,
// contention and parity checking, and first/second source transfers.
// Assumes all bus lanes and the sync input are synchronous to pclk, one
// bus cycle per clock, and that an outside wire-OR joins the lanes.
// Function
// - Address/control bus has five control and twenty address lines.
// - Initialize halts, puts processors in wait, zeroes counters, clears host regs; here only the status clears, masks are kept.
// - Clear-on-read processor status bits survive initialize.
// - Run line one lets processors run; zero halts them all.
// - Only host starts run; host or masked status may halt.
// - Write/read line one writes, zero reads.
// - Memory select one targets data memory, else non-memory decode.
// - Fast targets return read data at once.
// - Data memory returns read data about 450 ns later.
// - Counter loads, active/wait and channel writes carry data on address lanes.
// - Processor number in top bits; 110 counter, 111 status.
// - Two 4K other-device windows with twelve-bit offset.
// - Five status lines latch; halt and interrupt masks per line.
// - Status pulses last one cycle; latched until host reads.
// - Arithmetic error line reports overflow, range or comparison.
// - Parity error only on transfers out of data memory.
// - Busy page access pulses timing error and is discarded.
// - More than one source on a bus pulses contention line.
// - Every module works to the 50 ns bus cycle and sync.
// - Source drives whole cycle; all modules capture every cycle.
// - First drives second half, second drives first half; double both.
// - Sixteen data lines plus odd parity on every transfer.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
module bus_node #(
   parameter logic [3:0] PROC_ID = 4'h1,
   parameter logic [7:0] PAGE_ID = 8'h00,
   parameter int MEM_WORDS = 16,
   parameter int N_SRC = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bus_sync,
   input wire bus_node_pkg::am_s addr_ctrl_bus_lanes,
   input wire logic [bus_node_pkg::DM_W-1:0] data_bus_lanes,
   input wire logic [bus_node_pkg::ST_W-1:0] status_bus_lanes,
   input wire logic [N_SRC-1:0] dm_src_en,
   input wire logic [N_SRC-1:0] am_src_en,
   input wire logic arith_err_in,
   input wire logic [1:0] xfer_kind,
   input wire logic [bus_node_pkg::DATA_W-1:0] xfer_data,
   output logic xfer_busy,
   output logic [bus_node_pkg::DM_W-1:0] dm_out,
   output logic dm_oe,
   output logic initialize_line,
   output logic run_line,
   output logic [bus_node_pkg::ST_W-1:0] status_out,
   output logic host_irq,
   output logic proc_go,
   output logic [bus_node_pkg::OFS_W-1:0] pc_out,
   output logic [1:0] win_hit,
   output logic win_wr,
   output logic [bus_node_pkg::OFS_W-1:0] win_offset,
   output logic [bus_node_pkg::DM_W-1:0] store_data,
   output logic store_half
);
   localparam int IDX_W = $clog2(MEM_WORDS);
   localparam int CNT_W = 5;
   localparam int N = bus_node_pkg::SLOW_CYC;

   // True when more than one bit of a source-enable vector is set.
   function automatic logic many(input logic [N_SRC-1:0] v);
      many = |(v & (v - N_SRC'(1)));
   endfunction : many

   // Hit on this processor with the given three-bit register select.
   function automatic logic proc_hit(input bus_node_pkg::am_s a,
                                     input logic [2:0] sel);
      proc_hit = !a.mem && !a.addr[15] && a.addr[19:16] == PROC_ID &&
                 a.addr[14:12] == sel;
   endfunction : proc_hit

   // Odd parity word for the data lanes.
   function automatic logic [bus_node_pkg::DM_W-1:0] with_par(
      input logic [bus_node_pkg::DATA_W-1:0] d);
      with_par = {~^d, d};
   endfunction : with_par

   bus_node_pkg::am_s am_q, am_d;
   logic [bus_node_pkg::DM_W-1:0] dm_q, dm_d, dmo_q, dmo_d;
   logic dmoe_q, dmoe_d, half_q, half_d, shalf_q, shalf_d;
   logic rdy_q, rdy_d, err_q, err_d;
   logic [31:0] rd_q, rd_d;
   logic run_q, run_d, init_q, init_d, irq_q, irq_d, go_q, go_d;
   logic [bus_node_pkg::ST_W-1:0] ehs_q, ehs_d, hmr_q, hmr_d;
   logic [bus_node_pkg::ST_W-1:0] imr_q, imr_d, st_q, st_d;
   logic [bus_node_pkg::OFS_W-1:0] pc_q, pc_d, wofs_q, wofs_d;
   logic act_q, act_d;
   logic [bus_node_pkg::STAT_EN_W-1:0] sen_q, sen_d, stk_q, stk_d;
   logic [1:0] win_q, win_d, xk_q, xk_d;
   logic wwr_q, wwr_d;
   logic [bus_node_pkg::DATA_W-1:0] xd_q, xd_d;
   logic [bus_node_pkg::DATA_W-1:0] mem_q [MEM_WORDS];
   logic [bus_node_pkg::DATA_W-1:0] mem_d [MEM_WORDS];
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic busy_q, busy_d, rdp_q, rdp_d;
   logic [IDX_W-1:0] idx_q, idx_d;
   logic [N-1:0] mrd_q, mrd_d;

   // Next-state logic for the whole node; one bus cycle per clock.
   always_comb begin
      logic done, acc, rd_ehs, page_hit, host_halt, odd, aw_ok;
      logic [bus_node_pkg::ST_W-1:0] evt;
      logic [31:0] rdv;
      logic [IDX_W-1:0] ai;
      page_hit = 1'b0;
      done = psel && penable && rdy_q;
      acc = psel && penable && !rdy_q;
      rd_ehs = 1'b0;
      host_halt = 1'b0;
      rdv = 32'h0000_0000;
      evt = '0;
      ai = am_q.addr[IDX_W-1:0];
      odd = ^dm_q;
      aw_ok = PROC_ID != 4'h0 && PROC_ID <= 4'h7;
      // Every module captures the lanes every bus cycle.
      am_d = addr_ctrl_bus_lanes;
      dm_d = data_bus_lanes;
      half_d = bus_sync ? 1'b0 : ~half_q;
      shalf_d = half_q;
      rdy_d = acc;
      err_d = err_q;
      rd_d = rd_q;
      run_d = run_q;
      init_d = 1'b0;
      hmr_d = hmr_q;
      imr_d = imr_q;
      pc_d = pc_q;
      act_d = act_q;
      sen_d = sen_q;
      stk_d = stk_q;
      win_d = 2'b00;
      wwr_d = 1'b0;
      wofs_d = wofs_q;
      xk_d = xk_q;
      xd_d = xd_q;
      mem_d = mem_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      rdp_d = rdp_q;
      idx_d = idx_q;
      dmo_d = '0;
      dmoe_d = 1'b0;
      // The slave answers on the second access cycle.
      if (acc) begin
         err_d = 1'b0;
         case (paddr)
            bus_node_pkg::OFF_CTRL: rdv = {30'h0, init_q, run_q};
            bus_node_pkg::OFF_EHS: rdv = {27'h0, ehs_q};
            bus_node_pkg::OFF_HMR: rdv = {27'h0, hmr_q};
            bus_node_pkg::OFF_IMR: rdv = {27'h0, imr_q};
            bus_node_pkg::OFF_STATE: rdv = {16'h0000, irq_q, act_q, pc_q,
                                            go_q, run_q};
            default: err_d = 1'b1;
         endcase
         rd_d = pwrite ? 32'h0000_0000 : rdv;
      end
      // Register writes and read side effects at the completing edge.
      if (done && !err_q) begin
         if (pwrite) begin
            case (paddr)
               bus_node_pkg::OFF_CTRL: begin
                  init_d = pwdata[bus_node_pkg::CTRL_INIT];
                  if (pwdata[bus_node_pkg::CTRL_RUN]) begin
                     run_d = 1'b1;
                  end else begin
                     host_halt = 1'b1;
                  end
               end
               bus_node_pkg::OFF_HMR: hmr_d = pwdata[4:0];
               bus_node_pkg::OFF_IMR: imr_d = pwdata[4:0];
               default: ;
            endcase
         end else if (paddr == bus_node_pkg::OFF_EHS) begin
            rd_ehs = 1'b1;
         end
      end
      // Host halt, masked status halt; initialize forces halt.
      if (host_halt || init_d || |(status_bus_lanes & hmr_q)) begin
         run_d = 1'b0;
      end
      // Latched status; a pulse arriving on the read edge is kept.
      ehs_d = (rd_ehs ? '0 : ehs_q) | status_bus_lanes;
      if (init_d) begin
         ehs_d = '0;
      end
      irq_d = |(ehs_d & imr_q);
      // Processor register loads and reads; data rides the address lanes.
      if (proc_hit(am_q, bus_node_pkg::SEL_PC)) begin
         if (am_q.wr) begin
            pc_d = am_q.addr[11:0];
         end else begin
            dmo_d = with_par({4'h0, pc_q});
            dmoe_d = 1'b1;
         end
      end
      if (proc_hit(am_q, bus_node_pkg::SEL_STAT)) begin
         if (am_q.wr) begin
            sen_d = am_q.addr[3:0];
         end else begin
            dmo_d = with_par({8'h00, sen_q, stk_q});
            dmoe_d = 1'b1;
            stk_d = '0;
         end
      end
      // Active/wait word: pair 2k-1 is active, 2k-2 is wait.
      if (aw_ok && !am_q.mem && am_q.wr &&
          am_q.addr[19:14] == bus_node_pkg::ACTWAIT_HI) begin
         if (am_q.addr[2*PROC_ID-1] && !am_q.addr[2*PROC_ID-2]) begin
            act_d = 1'b1;
         end else if (am_q.addr[2*PROC_ID-2] && !am_q.addr[2*PROC_ID-1]) begin
            act_d = 1'b0;
         end
      end
      // Other-device windows.
      if (!am_q.mem && am_q.addr[19:14] == bus_node_pkg::WIN_HI &&
          am_q.addr[13]) begin
         win_d = am_q.addr[12] ? 2'b10 : 2'b01;
         wwr_d = am_q.wr;
         wofs_d = am_q.addr[11:0];
      end
      // Data memory page: write data comes with the address.
      page_hit = am_q.mem && am_q.addr[19:12] == PAGE_ID;
      if (busy_q) begin
         cnt_d = cnt_q - CNT_W'(1);
         if (cnt_q == CNT_W'(1)) begin
            busy_d = 1'b0;
            rdp_d = 1'b0;
            if (rdp_q) begin
               dmo_d = with_par(mem_q[idx_q]);
               dmoe_d = 1'b1;
            end
         end
      end
      if (page_hit && busy_q) begin
         evt[bus_node_pkg::ST_TIMING] = 1'b1;
      end else if (page_hit) begin
         busy_d = 1'b1;
         cnt_d = CNT_W'(N - 2);
         rdp_d = !am_q.wr;
         idx_d = ai;
         if (am_q.wr) begin
            mem_d[ai] = dm_q[15:0];
         end
      end
      // Parity is checked only on words returned by any memory page.
      mrd_d = {mrd_q[N-2:0], am_q.mem && !am_q.wr};
      evt[bus_node_pkg::ST_PARITY] = mrd_q[N-1] && !odd;
      // Contention checks on the current bus cycle's sources.
      evt[bus_node_pkg::ST_DM_CONT] = many(dm_src_en);
      evt[bus_node_pkg::ST_AM_CONT] = many(am_src_en);
      evt[bus_node_pkg::ST_ARITH] = arith_err_in;
      st_d = evt;
      // Local sticky status bits: a new event beats the read clear.
      stk_d[0] = stk_d[0] | arith_err_in;
      stk_d[1] = stk_d[1] | evt[bus_node_pkg::ST_TIMING];
      // Initialize on the lane: wait state and zero counter, sticky kept.
      if (am_q.init) begin
         pc_d = '0;
         act_d = 1'b0;
      end
      go_d = am_q.run && act_d && !am_q.init;
      // Source transfer: load now, drive in the selected half.
      if (xk_q == bus_node_pkg::XF_NONE) begin
         xk_d = xfer_kind;
         xd_d = xfer_data;
      end else if (!dmoe_d) begin
         if (half_d && xk_q[0]) begin
            dmo_d = with_par(xd_q);
            dmoe_d = 1'b1;
            xk_d = {xk_q[1], 1'b0};
         end else if (!half_d && xk_q[1] && !xk_q[0]) begin
            dmo_d = with_par(xd_q);
            dmoe_d = 1'b1;
            xk_d = 2'b00;
         end
      end
   end

   // State registers; clock enable low freezes everything.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         am_q <= '0;
         dm_q <= '0;
         dmo_q <= '0;
         dmoe_q <= 1'b0;
         half_q <= 1'b0;
         shalf_q <= 1'b0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         run_q <= 1'b0;
         init_q <= 1'b0;
         irq_q <= 1'b0;
         go_q <= 1'b0;
         ehs_q <= '0;
         hmr_q <= bus_node_pkg::MASK_RST;
         imr_q <= bus_node_pkg::MASK_RST;
         st_q <= '0;
         pc_q <= '0;
         wofs_q <= '0;
         act_q <= 1'b0;
         sen_q <= '0;
         stk_q <= '0;
         win_q <= 2'b00;
         wwr_q <= 1'b0;
         xk_q <= 2'b00;
         xd_q <= '0;
         mem_q <= '{default: '0};
         cnt_q <= '0;
         busy_q <= 1'b0;
         rdp_q <= 1'b0;
         idx_q <= '0;
         mrd_q <= '0;
      end else if (ce) begin
         am_q <= am_d;
         dm_q <= dm_d;
         dmo_q <= dmo_d;
         dmoe_q <= dmoe_d;
         half_q <= half_d;
         shalf_q <= shalf_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         rd_q <= rd_d;
         run_q <= run_d;
         init_q <= init_d;
         irq_q <= irq_d;
         go_q <= go_d;
         ehs_q <= ehs_d;
         hmr_q <= hmr_d;
         imr_q <= imr_d;
         st_q <= st_d;
         pc_q <= pc_d;
         wofs_q <= wofs_d;
         act_q <= act_d;
         sen_q <= sen_d;
         stk_q <= stk_d;
         win_q <= win_d;
         wwr_q <= wwr_d;
         xk_q <= xk_d;
         xd_q <= xd_d;
         mem_q <= mem_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         rdp_q <= rdp_d;
         idx_q <= idx_d;
         mrd_q <= mrd_d;
      end
   end

   // Every output is a register, except pslverr and xfer_busy, which are decoded from registers.
   assign prdata = rd_q;
   assign pready = rdy_q;
   assign pslverr = err_q && rdy_q;
   assign xfer_busy = xk_q != bus_node_pkg::XF_NONE;
   assign dm_out = dmo_q;
   assign dm_oe = dmoe_q;
   assign initialize_line = init_q;
   assign run_line = run_q;
   assign status_out = st_q;
   assign host_irq = irq_q;
   assign proc_go = go_q;
   assign pc_out = pc_q;
   assign win_hit = win_q;
   assign win_wr = wwr_q;
   assign win_offset = wofs_q;
   assign store_data = dm_q;
   assign store_half = shalf_q;
endmodule : bus_node

// >>> logic/bus_node_pkg.sv
// Package for the synchronous backplane bus node: lane layouts, register
// offsets, field positions, reset values and bus timing counts.
// Assumes one 20 MHz clock, one bus cycle per clock.
package bus_node_pkg;
   // Address/control lanes: five control lines and twenty address lines.
   localparam int ADDR_W = 20;
   localparam int AM_W = 25;
   localparam int DATA_W = 16;
   localparam int DM_W = 17;
   typedef struct packed {
      logic init;
      logic run;
      logic spare;
      logic wr;
      logic mem;
      logic [ADDR_W-1:0] addr;
   } am_s;
   // Transfer timing selection for a source transfer.
   typedef enum logic [1:0] {
      XF_NONE = 2'b00,
      XF_FIRST = 2'b01,
      XF_SECOND = 2'b10,
      XF_DOUBLE = 2'b11
   } xfer_e;
   // Status lane bit positions.
   localparam int ST_ARITH = 0;
   localparam int ST_PARITY = 1;
   localparam int ST_TIMING = 2;
   localparam int ST_DM_CONT = 3;
   localparam int ST_AM_CONT = 4;
   localparam int ST_W = 5;
   // Processor decode fields.
   localparam logic [2:0] SEL_PC = 3'h6;
   localparam logic [2:0] SEL_STAT = 3'h7;
   localparam logic [5:0] ACTWAIT_HI = 6'h01;
   localparam logic [5:0] WIN_HI = 6'h00;
   localparam logic [1:0] WIN0 = 2'h2;
   localparam logic [1:0] WIN1 = 2'h3;
   localparam int OFS_W = 12;
   localparam int STAT_EN_W = 4;
   // Register offsets on the APB slave.
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_EHS = 12'h004;
   localparam logic [11:0] OFF_HMR = 12'h008;
   localparam logic [11:0] OFF_IMR = 12'h00c;
   localparam logic [11:0] OFF_STATE = 12'h010;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_INIT = 1;
   localparam logic [ST_W-1:0] MASK_RST = 5'h00;
   // Bus timing.
   localparam int CLK_NS = 50;
   localparam int FAST_NS = 15;
   localparam int SLOW_NS = 450;
   localparam int SLOW_CYC = SLOW_NS / CLK_NS;
endpackage : bus_node_pkg

// >>> tb/bus_node_checker.sv
// Checker for the bus node: concurrent properties on the top ports.
// Assumes ce is held high, so every rising edge is one bus cycle.
`timescale 1ns/100ps
module bus_node_checker #(
   parameter int N_SRC = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire bus_node_pkg::am_s addr_ctrl_bus_lanes,
   input wire logic [N_SRC-1:0] dm_src_en,
   input wire logic [N_SRC-1:0] am_src_en,
   input wire logic [bus_node_pkg::DM_W-1:0] dm_out,
   input wire logic dm_oe,
   input wire logic initialize_line,
   input wire logic run_line,
   input wire logic [bus_node_pkg::ST_W-1:0] status_out,
   input wire logic proc_go,
   input wire logic [1:0] win_hit
);
   bus_node_pkg::am_s am;
   logic w0;
   logic w1;
   logic host_wr;
   // Window patterns and host writes, recomputed here from the pins.
   assign am = addr_ctrl_bus_lanes;
   assign w0 = !am.mem && am.addr[19:12] == 8'h02;
   assign w1 = !am.mem && am.addr[19:12] == 8'h03;
   assign host_wr = psel && penable && pready && pwrite;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_init_pulse:
      assert property (initialize_line |=> !initialize_line)
      else $error("initialize pulse longer than one cycle");
   a_init_by_host:
      assert property ($rose(initialize_line) |-> $past(host_wr))
      else $error("initialize without a host write");
   a_init_stops_run:
      assert property (initialize_line |=> !run_line)
      else $error("run still set after initialize");
   a_init_blocks_go:
      assert property (am.init |-> ##2 (!proc_go) [*3])
      else $error("processor going after initialize");
   a_halt_blocks_go:
      assert property ((!am.run) [*3] |-> !proc_go)
      else $error("processor going while halted");
   a_run_by_host:
      assert property ($rose(run_line) |-> $past(host_wr))
      else $error("run started without a host write");
   a_dm_cont_flag:
      assert property (1'b1 |=> status_out[bus_node_pkg::ST_DM_CONT]
         == ($countones($past(dm_src_en)) > 1))
      else $error("data contention pulse wrong");
   a_am_cont_flag:
      assert property (1'b1 |=> status_out[bus_node_pkg::ST_AM_CONT]
         == ($countones($past(am_src_en)) > 1))
      else $error("address contention pulse wrong");
   a_dm_odd_parity:
      assert property (dm_oe |-> ^dm_out)
      else $error("data bus word without odd parity");
   a_win0_decode:
      assert property (win_hit[0] |-> $past(w0) || $past(w0, 2))
      else $error("window 0 hit without its address");
   a_win1_decode:
      assert property (win_hit[1] |-> $past(w1) || $past(w1, 2))
      else $error("window 1 hit without its address");
endmodule : bus_node_checker
bind bus_node bus_node_checker #(.N_SRC(N_SRC)) u_checker (.pclk,
   .presetn, .psel, .penable, .pwrite, .pready, .addr_ctrl_bus_lanes,
   .dm_src_en, .am_src_en, .dm_out, .dm_oe, .initialize_line,
   .run_line, .status_out, .proc_go, .win_hit);

// >>> tb/bus_peers.sv
// Far-side peers on the backplane: one peer source plus the wired lanes.
// Assumes the bench raises send for one bus cycle per peer word.
`timescale 1ns/100ps
module bus_peers (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic send,
   input wire bus_node_pkg::am_s send_am,
   input wire logic [15:0] send_dm,
   input wire logic init_line,
   input wire logic run_line,
   input wire logic [16:0] node_dm,
   input wire logic node_oe,
   input wire logic [4:0] node_st,
   output bus_node_pkg::am_s am,
   output logic [16:0] dm,
   output logic [4:0] st
);
   logic [16:0] last_q;
   // The peer drives a whole cycle; address and data share that cycle.
   always_comb begin
      am = send ? send_am : '0;
      am.init = init_line;
      am.run = run_line;
   end
   // Nobody drives the data lanes between words, so they float; the
   // inverse of the last word keeps a stale value from passing.
   assign dm = node_oe ? node_dm : send ? {~^send_dm, send_dm}
      : ~last_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= '0;
      end else begin
         last_q <= dm;
      end
   end
   // Status lanes are a wired OR; the peers raise nothing themselves.
   assign st = node_st;
endmodule : bus_peers

// >>> tb/bus_node_tb.sv
// Testbench for the bus node: APB host accesses and peer bus words.
// Assumes the design's registered answers and one peer model.
`timescale 1ns/100ps
module bus_node_tb;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic bus_sync, arith_err_in, xfer_busy, dm_oe, initialize_line;
   logic run_line, host_irq, proc_go, win_wr, store_half, send, e;
   logic [11:0] paddr, pc_out, win_offset, off;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] dm_src_en, am_src_en;
   logic [1:0] xfer_kind, win_hit, hit_or;
   logic [15:0] xfer_data, send_dm;
   logic [16:0] dm_out, dm, store_data, word;
   logic [4:0] status_out, st, st_or;
   bus_node_pkg::am_s am, send_am;
   int error_cnt, comparisons, oe_cnt, lat;
   logic wr_seen;
   bus_node dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bus_sync,
      .addr_ctrl_bus_lanes(am), .data_bus_lanes(dm),
      .status_bus_lanes(st), .dm_src_en, .am_src_en, .arith_err_in,
      .xfer_kind, .xfer_data, .xfer_busy, .dm_out, .dm_oe,
      .initialize_line, .run_line, .status_out, .host_irq, .proc_go,
      .pc_out, .win_hit, .win_wr, .win_offset, .store_data, .store_half);
   bus_peers peers (.pclk, .presetn, .send, .send_am, .send_dm,
      .init_line(initialize_line), .run_line, .node_dm(dm_out),
      .node_oe(dm_oe), .node_st(status_out), .am, .dm, .st);
   // Free-running clock and a sync that marks every other bus cycle.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) bus_sync <= presetn & ~bus_sync;
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is seen high or 50 cycles pass.
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rq, output logic re);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) error_cnt++;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, '0, q, e);
      chk(q, x);
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask : wr
   function automatic bus_node_pkg::am_s mk(logic w, logic m,
      logic [19:0] a);
      mk = '{1'b0, 1'b0, 1'b0, w, m, a};
   endfunction : mk
   task automatic put(input bus_node_pkg::am_s a, input logic [15:0] d);
      @(posedge pclk);
      send <= 1'b1;
      send_am <= a;
      send_dm <= d;
      @(posedge pclk);
      send <= 1'b0;
   endtask : put
   // Samples before each edge's updates land, so results never race.
   task automatic watch(input int n);
      oe_cnt = 0;
      lat = 0;
      st_or = '0;
      hit_or = '0;
      wr_seen = 1'b0;
      for (int i = 1; i <= n; i++) begin
         @(posedge pclk);
         if (dm_oe === 1'b1) begin
            if (oe_cnt == 0) lat = i;
            oe_cnt++;
            word = dm_out;
         end
         st_or |= status_out;
         hit_or |= win_hit;
         if (win_hit !== 2'b00) off = win_offset;
         wr_seen |= win_wr;
      end
   endtask : watch
   task automatic pulse(input int b);
      @(posedge pclk);
      arith_err_in <= (b == 0);
      dm_src_en <= (b == 1) ? 4'h5 : 4'h0;
      am_src_en <= (b == 2) ? 4'h3 : 4'h0;
      @(posedge pclk);
      arith_err_in <= 1'b0;
      dm_src_en <= 4'h0;
      am_src_en <= 4'h0;
   endtask : pulse
   task automatic complete_run;
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   // The whole run needs well under a thousand cycles.
   initial begin
      repeat (4000) @(posedge pclk);
      error_cnt++;
      complete_run();
   end
   initial begin
      {psel, penable, pwrite, send, arith_err_in} = '0;
      {paddr, pwdata, dm_src_en, am_src_en} = '0;
      {xfer_kind, xfer_data, send_am, send_dm} = '0;
      ce = 1'b1;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(bus_node_pkg::OFF_HMR, 32'h0);
      rd(bus_node_pkg::OFF_IMR, 32'h0);
      wr(bus_node_pkg::OFF_IMR, 32'hffffffff);
      rd(bus_node_pkg::OFF_IMR, 32'h1f);
      apb(1'b0, 12'h020, '0, q, e);
      chk(32'(e), 32'h1);
      $display("test registers done");
      for (int w = 0; w < 2; w++) begin
         for (int k = 0; k < 3; k++) begin
            put(mk(k != 1, k == 2, {6'h0, 2'(w + 2), 12'h120}), 16'h0);
            watch(4);
            chk(32'(hit_or), k < 2 ? 32'(w + 1) : 32'h0);
            chk(32'(wr_seen), 32'(k == 0));
         end
         chk(32'(off), 32'h120);
      end
      $display("test windows done");
      put(mk(1'b1, 1'b1, 20'h00003), 16'h1234);
      repeat (12) @(posedge pclk);
      put(mk(1'b0, 1'b1, 20'h00003), 16'h0);
      put(mk(1'b1, 1'b1, 20'h00003), 16'hbeef);
      watch(14);
      chk(32'(oe_cnt), 32'h1);
      chk(32'(word[15:0]), 32'h1234);
      chk(32'(st_or[bus_node_pkg::ST_TIMING]), 32'h1);
      put(mk(1'b0, 1'b1, 20'h00003), 16'h0);
      watch(12);
      chk(32'(lat), 32'd9);
      chk(32'(word[15:0]), 32'h1234);
      rd(bus_node_pkg::OFF_EHS, 32'h4);
      $display("test memory done");
      put(mk(1'b1, 1'b0, {5'h02, bus_node_pkg::SEL_PC, 12'h05a}), 16'h0);
      put(mk(1'b0, 1'b0, {5'h02, bus_node_pkg::SEL_PC, 12'h000}), 16'h0);
      watch(4);
      chk(32'(pc_out), 32'h05a);
      chk(32'(lat), 32'h2);
      chk(32'(word[11:0]), 32'h05a);
      $display("test fast read done");
      for (int b = 0; b < 3; b++) begin
         pulse(b);
         rd(bus_node_pkg::OFF_EHS, 32'h1 << (b == 0 ? 0 : b + 2));
         rd(bus_node_pkg::OFF_EHS, 32'h0);
      end
      wr(bus_node_pkg::OFF_HMR, 32'h8);
      wr(bus_node_pkg::OFF_CTRL, 32'h1);
      @(posedge pclk);
      chk(32'(run_line), 32'h1);
      pulse(1);
      repeat (4) @(posedge pclk);
      chk(32'(host_irq), 32'h1);
      chk(32'(run_line), 32'h0);
      rd(bus_node_pkg::OFF_EHS, 32'h8);
      repeat (2) @(posedge pclk);
      chk(32'(host_irq), 32'h0);
      $display("test status done");
      wr(bus_node_pkg::OFF_HMR, 32'h0);
      wr(bus_node_pkg::OFF_CTRL, 32'h1);
      pulse(0);
      wr(bus_node_pkg::OFF_CTRL, 32'h2);
      repeat (3) @(posedge pclk);
      chk(32'(run_line), 32'h0);
      chk(32'(pc_out), 32'h0);
      rd(bus_node_pkg::OFF_EHS, 32'h0);
      $display("test initialize done");
      wr(bus_node_pkg::OFF_CTRL, 32'h1);
      for (int k = 1; k < 4; k++) begin
         @(posedge pclk);
         xfer_kind <= 2'(k);
         xfer_data <= 16'ha5a0 + 16'(k);
         @(posedge pclk);
         xfer_kind <= 2'b00;
         watch(8);
         chk(32'(oe_cnt), k == 3 ? 32'h2 : 32'h1);
         chk(32'(word[15:0]), 32'ha5a0 + 32'(k));
         chk(32'(xfer_busy), 32'h0);
      end
      $display("test transfers done");
      complete_run();
   end
endmodule : bus_node_tb
